/* File: hdl/rcc_pkg.sv */
// Constants for the reader configuration command handler.
// Assumes one 20 MHz clock; no timing counts are needed here.
package rcc_pkg;
  // Command and reply characters
  localparam logic [7:0] CH_O     = 8'h6F;
  localparam logic [7:0] CH_F     = 8'h66;
  localparam logic [7:0] CH_G     = 8'h67;
  localparam logic [7:0] CH_M     = 8'h6D;
  localparam logic [7:0] CH_X     = 8'h78;
  localparam logic [7:0] CH_T     = 8'h74;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_ERR   = 8'h52;
  localparam logic [7:0] CH_RLD   = 8'h58;
  localparam logic [7:0] CH_OU    = 8'h4F;
  localparam logic [7:0] CASE_OFS = 8'h20;
  // Argument layout
  localparam logic [7:0] FT_UNUSED = 8'h0C;
  localparam logic [7:0] RT_UNUSED = 8'h0B;
  localparam logic [7:0] RT_MODC   = 8'h09;
  localparam logic [7:0] MAX_BAUD  = 8'h06;
  // Tag mask bit positions
  localparam int TB_A = 0;
  localparam int TB_B = 1;
  localparam int TB_D = 2;
  localparam int TB_E = 3;
  localparam int TB_I = 4;
  localparam int TB_S = 5;
  localparam int TB_V = 6;
  // Start-up image reset values
  localparam logic [6:0] TAG_ALL   = 7'h7F;
  localparam logic [7:0] PCFG_RST  = 8'h00;
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] MOD_RST   = 8'h00;
  localparam logic       PROTO_RST = 1'b0;
  localparam logic [2:0] BAUD_RST  = 3'h0;
  // Register port byte addresses and upper-bit range selects
  localparam logic [7:0] A_S_TAG   = 8'h00;
  localparam logic [7:0] A_S_PROTO = 8'h04;
  localparam logic [7:0] A_S_BAUD  = 8'h08;
  localparam logic [7:0] A_TAG     = 8'h0C;
  localparam logic [3:0] A_S_PCFG  = 4'h1;
  localparam logic [3:0] A_S_MOD   = 4'h2;
  localparam logic [3:0] A_PCFG    = 4'h3;
  localparam logic [1:0] A_S_CFG   = 2'h1;
  localparam logic [1:0] A_CFG     = 2'h2;
  localparam logic [3:0] A_MOD     = 4'hC;
  localparam logic [7:0] A_STATUS  = 8'hD0;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SUB   = 3'b001,
    S_ARG   = 3'b011,
    S_EXEC  = 3'b010,
    S_REPLY = 3'b110
  } rcc_st_t;
endpackage

/* File: hdl/rcc_cmd_handler.sv */
// Reader configuration command handler: parses text commands, applies
// run-time settings and returns the acknowledge characters.
// Assumes a byte stream on ref_clk from the serial receiver and a
// transmitter that takes reply characters by valid/ready.
// Overview of operation
// [R1] Tag type letter a,b,d,e,i,s,t,v; t enables all, others pick one.
// [R2] With one tag type selected, polling covers only that type.
// [R3] Reset restores tag selection from the start-up image.
// [R4] The proprietary Type A family is polled exactly when Type A is.
// [R5] Flag command takes type and value, applies at once, replies one byte.
// [R6] Flag writes never reach the stored image; reset reverts them.
// [R7] Successful flag reply is the flag's current state, one byte.
// [R8] Flag types 00h-05h hit protocol register 1, values 00 or 01.
// [R9] Flag types 06h-0Ah hit protocol register 2.
// [R10] Flag type 08h is two bits, values 00 to 03.
// [R11] Types 0Bh,0Dh-11h,13h to register 3; 12h,14h,15h to register 4.
// [R12] Unknown flag type changes nothing and replies R.
// [R13] Register command takes type and value, applies, replies one byte.
// [R14] Register types 00h-0Ah and 0Ch-0Fh map to configuration registers.
// [R15] Bad register type or value changes nothing and replies R.
// [R16] Modulation select 00h-03h replies index then that register's value.
// [R17] Modulation register 0 is active after start-up.
// [R18] Modulation index above 03h is refused with R.
// [R19] Host loads modulation registers 1-3 before selecting them.
// [R20] Reload applies stored settings, replies X, protocol, baud rate.
// [R21] Protocol code 00h is text, 01h is binary.
// [R22] Baud rate code lies in 00h-06h.
// [R23] Byte arguments and replies travel as two hex characters.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcc_cmd_handler
  import rcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [7:0]       bus_rdata,
  output logic [7:0]       poll_mask,
  output logic [7:0]       pcfg_1,
  output logic [7:0]       pcfg_2,
  output logic [7:0]       pcfg_3,
  output logic [7:0]       pcfg_4,
  output logic [7:0]       mod_cond,
  output logic [15:0]      poll_timer,
  output logic             skip_rx_frame_start,
  output logic             skip_rx_extra_guard,
  output logic             skip_rx_frame_end,
  output logic             proto_code,
  output logic [2:0]       baud_code
);

  typedef struct packed {
    rcc_st_t          st;
    logic [7:0]       sub;
    logic [2:0]       nib;
    logic [15:0]      arg;
    logic [6:0]       tag;
    logic [3:0][7:0]  pcfg;
    logic [15:0][7:0] cfg;
    logic [3:0][7:0]  mod;
    logic [1:0]       mod_sel;
    logic             proto;
    logic [2:0]       baud;
    logic [6:0]       s_tag;
    logic [3:0][7:0]  s_pcfg;
    logic [15:0][7:0] s_cfg;
    logic [3:0][7:0]  s_mod;
    logic             s_proto;
    logic [2:0]       s_baud;
    logic [4:0][7:0]  txb;
    logic [2:0]       txn;
    logic [7:0]       rdata;
  } rcc_state_t;

  rcc_state_t r_r;
  rcc_state_t r_nxt;
  logic [7:0] ch;
  logic [4:0] hv;
  logic [6:0] fm;
  logic [7:0] tb;
  logic [7:0] tc;
  logic [7:0] av;
  logic [7:0] at;
  logic       f_ok;
  logic       g_ok;
  logic       rx_acc;
  logic       tx_acc;

  function automatic logic [7:0] lower(input logic [7:0] c);
    lower = (c >= 8'h41 && c <= 8'h5A) ? c | CASE_OFS : c;
  endfunction

  // Bit 4 marks a valid hex digit
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
      hex_val = {1'b1, c[3:0]};
    else if (lower(c) >= 8'h61 && lower(c) <= 8'h66)
      hex_val = {1'b1, 4'(c[3:0] + 4'h9)};
    else
      hex_val = 5'h00;
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // Bit 7 valid, rest is the mask bit of the letter
  function automatic logic [7:0] tag_bit(input logic [7:0] c);
    tag_bit = 8'h00;
    case (c)
      8'h61: tag_bit = 8'h80 | 8'(1 << TB_A);
      8'h62: tag_bit = 8'h80 | 8'(1 << TB_B);
      8'h64: tag_bit = 8'h80 | 8'(1 << TB_D);
      8'h65: tag_bit = 8'h80 | 8'(1 << TB_E);
      8'h69: tag_bit = 8'h80 | 8'(1 << TB_I);
      8'h73: tag_bit = 8'h80 | 8'(1 << TB_S);
      8'h76: tag_bit = 8'h80 | 8'(1 << TB_V);
      8'h74: tag_bit = 8'h80;
      default: tag_bit = 8'h00;
    endcase
  endfunction

  // {valid, register 0..3, bit, two-bit field}
  function automatic logic [6:0] flag_map(input logic [7:0] t);
    case (t)
      8'h00: flag_map = {1'b1, 2'd0, 3'd0, 1'b0};
      8'h01: flag_map = {1'b1, 2'd0, 3'd1, 1'b0};
      8'h02: flag_map = {1'b1, 2'd0, 3'd2, 1'b0};
      8'h03: flag_map = {1'b1, 2'd0, 3'd3, 1'b0};
      8'h04: flag_map = {1'b1, 2'd0, 3'd4, 1'b0};
      8'h05: flag_map = {1'b1, 2'd0, 3'd5, 1'b0};
      8'h06: flag_map = {1'b1, 2'd1, 3'd0, 1'b0};
      8'h07: flag_map = {1'b1, 2'd1, 3'd1, 1'b0};
      8'h08: flag_map = {1'b1, 2'd1, 3'd2, 1'b1};
      8'h09: flag_map = {1'b1, 2'd1, 3'd4, 1'b0};
      8'h0A: flag_map = {1'b1, 2'd1, 3'd5, 1'b0};
      8'h0B: flag_map = {1'b1, 2'd2, 3'd0, 1'b0};
      8'h0D: flag_map = {1'b1, 2'd2, 3'd1, 1'b0};
      8'h0E: flag_map = {1'b1, 2'd2, 3'd2, 1'b0};
      8'h0F: flag_map = {1'b1, 2'd2, 3'd3, 1'b0};
      8'h10: flag_map = {1'b1, 2'd2, 3'd4, 1'b0};
      8'h11: flag_map = {1'b1, 2'd2, 3'd5, 1'b0};
      8'h13: flag_map = {1'b1, 2'd2, 3'd6, 1'b0};
      8'h12: flag_map = {1'b1, 2'd3, 3'd0, 1'b0};
      8'h14: flag_map = {1'b1, 2'd3, 3'd1, 1'b0};
      8'h15: flag_map = {1'b1, 2'd3, 3'd2, 1'b0};
      default: flag_map = 7'h00;
    endcase
  endfunction

  assign ch       = lower(rx_data);
  assign hv       = hex_val(rx_data);
  assign at       = r_r.arg[15:8];
  assign av       = r_r.arg[7:0];
  assign fm       = flag_map(at);
  assign tb       = tag_bit(r_r.sub);
  assign tc       = tag_bit(ch);
  // Binary flags take 00/01, the wide one 00..03
  assign f_ok     = fm[6] && av[7:2] == 6'h00 && (fm[0] || !av[1]); // R8 R10
  assign g_ok     = at[7:4] == 4'h0 && at != RT_UNUSED; // R14 R15
  // Frozen clock enable also blocks both handshakes
  assign rx_ready = ce && (r_r.st == S_IDLE || r_r.st == S_SUB ||
                           r_r.st == S_ARG);
  assign tx_valid = ce && r_r.st == S_REPLY;
  assign rx_acc   = rx_valid && rx_ready;
  assign tx_acc   = tx_valid && tx_ready;

  assign tx_data             = r_r.txb[0];
  assign bus_rdata           = r_r.rdata;
  assign poll_mask           = {r_r.tag[TB_A], r_r.tag}; // R2 R4
  assign pcfg_1              = r_r.pcfg[0];
  assign pcfg_2              = r_r.pcfg[1];
  assign pcfg_3              = r_r.pcfg[2];
  assign pcfg_4              = r_r.pcfg[3];
  assign mod_cond            = r_r.mod[r_r.mod_sel];
  assign poll_timer          = {r_r.cfg[2], r_r.cfg[1]};
  assign skip_rx_frame_start = r_r.pcfg[2][2];
  assign skip_rx_extra_guard = r_r.pcfg[2][3];
  assign skip_rx_frame_end   = r_r.pcfg[2][4];
  assign proto_code          = r_r.proto;
  assign baud_code           = r_r.baud;

  always_comb
  begin
    r_nxt = r_r;
    if (ce)
    begin
      // Register port: stored image is writable, run-time state read-only
      r_nxt.rdata = 8'h00;
      if (bus_wr)
      begin
        if (bus_addr == A_S_TAG)
          r_nxt.s_tag = bus_wdata[6:0];
        else if (bus_addr == A_S_PROTO)
          r_nxt.s_proto = bus_wdata[0]; // R21
        else if (bus_addr == A_S_BAUD)
        begin
          if (bus_wdata <= MAX_BAUD)
            r_nxt.s_baud = bus_wdata[2:0]; // R22
        end
        else if (bus_addr[7:4] == A_S_PCFG)
          r_nxt.s_pcfg[bus_addr[3:2]] = bus_wdata;
        else if (bus_addr[7:4] == A_S_MOD)
          r_nxt.s_mod[bus_addr[3:2]] = bus_wdata;
        else if (bus_addr[7:6] == A_S_CFG)
          r_nxt.s_cfg[bus_addr[5:2]] = bus_wdata;
      end
      if (bus_rd)
      begin
        if (bus_addr == A_S_TAG)
          r_nxt.rdata = {1'b0, r_r.s_tag};
        else if (bus_addr == A_S_PROTO)
          r_nxt.rdata = {7'h00, r_r.s_proto};
        else if (bus_addr == A_S_BAUD)
          r_nxt.rdata = {5'h00, r_r.s_baud};
        else if (bus_addr == A_TAG)
          r_nxt.rdata = poll_mask;
        else if (bus_addr == A_STATUS)
          r_nxt.rdata = {1'b0, r_r.st != S_IDLE, r_r.proto, r_r.baud,
                         r_r.mod_sel};
        else if (bus_addr[7:4] == A_S_PCFG)
          r_nxt.rdata = r_r.s_pcfg[bus_addr[3:2]];
        else if (bus_addr[7:4] == A_S_MOD)
          r_nxt.rdata = r_r.s_mod[bus_addr[3:2]];
        else if (bus_addr[7:4] == A_PCFG)
          r_nxt.rdata = r_r.pcfg[bus_addr[3:2]];
        else if (bus_addr[7:4] == A_MOD)
          r_nxt.rdata = r_r.mod[bus_addr[3:2]];
        else if (bus_addr[7:6] == A_S_CFG)
          r_nxt.rdata = r_r.s_cfg[bus_addr[5:2]];
        else if (bus_addr[7:6] == A_CFG)
          r_nxt.rdata = r_r.cfg[bus_addr[5:2]];
      end

      case (r_r.st)
        S_IDLE:
        begin
          if (rx_acc && ch == CH_O)
            r_nxt.st = S_SUB;
        end
        S_SUB:
        begin
          if (rx_acc)
          begin
            r_nxt.sub = ch;
            r_nxt.arg = 16'h0000;
            if (ch == CH_F || ch == CH_G)
            begin
              r_nxt.nib = 3'd4; // R23
              r_nxt.st  = S_ARG;
            end
            else if (ch == CH_M)
            begin
              r_nxt.nib = 3'd2; // R23
              r_nxt.st  = S_ARG;
            end
            else if (ch == CH_X || tc[7])
              r_nxt.st = S_EXEC; // R1
            else
            begin
              r_nxt.txb    = '0;
              r_nxt.txb[0] = CH_ERR;
              r_nxt.txn    = 3'd1;
              r_nxt.st     = S_REPLY;
            end
          end
        end
        S_ARG:
        begin
          // Spaces between hex pairs are tolerated
          if (rx_acc && hv[4])
          begin
            r_nxt.arg = {r_r.arg[11:0], hv[3:0]}; // R23
            r_nxt.nib = r_r.nib - 3'd1;
            if (r_r.nib == 3'd1)
              r_nxt.st = S_EXEC;
          end
          else if (rx_acc && rx_data != CH_SP)
          begin
            r_nxt.txb    = '0;
            r_nxt.txb[0] = CH_ERR;
            r_nxt.txn    = 3'd1;
            r_nxt.st     = S_REPLY;
          end
        end
        S_EXEC:
        begin
          r_nxt.st     = S_REPLY;
          r_nxt.txb    = '0;
          r_nxt.txb[0] = CH_ERR; // R12 R15 R18
          r_nxt.txn    = 3'd1;
          if (r_r.sub == CH_F)
          begin
            if (f_ok)
            begin
              // Only run-time copy changes; stored image untouched
              r_nxt.pcfg[fm[5:4]][fm[3:1]] = av[0]; // R5 R6 R9 R11
              if (fm[0])
                r_nxt.pcfg[fm[5:4]][fm[3:1] + 3'd1] = av[1]; // R10
              r_nxt.txb[0] = hexc(av[7:4]); // R7
              r_nxt.txb[1] = hexc(av[3:0]);
              r_nxt.txn    = 3'd2;
            end
          end
          else if (r_r.sub == CH_G)
          begin
            if (g_ok)
            begin
              if (at == RT_MODC)
                r_nxt.mod[r_r.mod_sel] = av; // R14
              else
                r_nxt.cfg[at[3:0]] = av; // R13
              r_nxt.txb[0] = hexc(av[7:4]);
              r_nxt.txb[1] = hexc(av[3:0]);
              r_nxt.txn    = 3'd2;
            end
          end
          else if (r_r.sub == CH_M)
          begin
            if (av[7:2] == 6'h00)
            begin
              r_nxt.mod_sel = av[1:0]; // R16
              r_nxt.txb[0]  = hexc(av[7:4]);
              r_nxt.txb[1]  = hexc(av[3:0]);
              r_nxt.txb[2]  = hexc(r_r.mod[av[1:0]][7:4]);
              r_nxt.txb[3]  = hexc(r_r.mod[av[1:0]][3:0]);
              r_nxt.txn     = 3'd4;
            end
          end
          else if (r_r.sub == CH_X)
          begin
            r_nxt.tag    = r_r.s_tag; // R20
            r_nxt.pcfg   = r_r.s_pcfg;
            r_nxt.cfg    = r_r.s_cfg;
            r_nxt.mod    = r_r.s_mod;
            r_nxt.proto  = r_r.s_proto;
            r_nxt.baud   = r_r.s_baud;
            r_nxt.txb[0] = CH_RLD;
            r_nxt.txb[1] = hexc(4'h0);
            r_nxt.txb[2] = hexc({3'h0, r_r.s_proto}); // R21
            r_nxt.txb[3] = hexc(4'h0);
            r_nxt.txb[4] = hexc({1'b0, r_r.s_baud}); // R22
            r_nxt.txn    = 3'd5;
          end
          else
          begin
            // Single letter other than a or t leaves one protocol in the poll round; a leaves Type A and its family; t leaves all
            r_nxt.tag    = (r_r.sub == CH_T) ? TAG_ALL : tb[6:0]; // R1 R2
            r_nxt.txb[0] = CH_OU;
            r_nxt.txb[1] = r_r.sub - CASE_OFS;
            r_nxt.txn    = 3'd2;
          end
        end
        S_REPLY:
        begin
          if (tx_acc)
          begin
            r_nxt.txb = {8'h00, r_r.txb[4:1]};
            r_nxt.txn = r_r.txn - 3'd1;
            if (r_r.txn == 3'd1)
              r_nxt.st = S_IDLE;
          end
        end
        default:
          r_nxt.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_r         <= '0;
      r_r.st      <= S_IDLE;
      r_r.tag     <= TAG_ALL; // R3
      r_r.s_tag   <= TAG_ALL;
      r_r.pcfg    <= {4{PCFG_RST}}; // R6
      r_r.s_pcfg  <= {4{PCFG_RST}};
      r_r.cfg     <= {16{CFG_RST}};
      r_r.s_cfg   <= {16{CFG_RST}};
      r_r.mod     <= {4{MOD_RST}};
      r_r.s_mod   <= {4{MOD_RST}};
      r_r.mod_sel <= 2'd0; // R17
      r_r.proto   <= PROTO_RST;
      r_r.s_proto <= PROTO_RST;
      r_r.baud    <= BAUD_RST;
      r_r.s_baud  <= BAUD_RST;
    end
    else
      r_r <= r_nxt;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic ex;
  assign ex = ce && r_r.st == S_EXEC;

  poll_single_a: assert property ( // R2
    ex && tb[7] && r_r.sub != CH_T |=> $onehot(poll_mask[6:0]))
    else $error("single tag type not alone in poll mask");
  // Reset is the trigger here, so the default disable must not apply
  reset_tag_a: assert property (disable iff (1'b0) // R3
    rst |=> r_r.tag == TAG_ALL && r_r.mod_sel == 2'd0)
    else $error("reset did not restore start-up selection");
  family_poll_a: assert property ( // R4
    ex && tb[7] |=> poll_mask[7] == (tb[TB_A] || r_r.sub == CH_T))
    else $error("type A family poll mismatch");
  flag_reply_a: assert property ( // R7
    ex && r_r.sub == CH_F && f_ok |=> r_r.txn == 3'd2 &&
    r_r.txb[1] == hexc(av[3:0]))
    else $error("flag reply not one byte of value");
  wide_flag_a: assert property ( // R10
    ex && r_r.sub == CH_F && at == 8'h08 && av == 8'h03
    |=> r_r.pcfg[1][3:2] == 2'd3)
    else $error("two-bit flag not written");
  bad_flag_a: assert property ( // R12
    ex && r_r.sub == CH_F && !f_ok
    |=> $stable(r_r.pcfg) && tx_data == CH_ERR && r_r.txn == 3'd1)
    else $error("bad flag not refused");
  bad_reg_a: assert property ( // R15
    ex && r_r.sub == CH_G && !g_ok |=> $stable(r_r.cfg) && $stable(r_r.mod))
    else $error("bad register type changed state");
  mod_reply_a: assert property ( // R16
    ex && r_r.sub == CH_M && av[7:2] == 6'h00
    |=> r_r.txn == 3'd4 && r_r.mod_sel == $past(av[1:0]))
    else $error("modulation select reply wrong");
  mod_bad_a: assert property ( // R18
    ex && r_r.sub == CH_M && av[7:2] != 6'h00 |=> $stable(r_r.mod_sel))
    else $error("bad modulation index accepted");
  reload_a: assert property ( // R20
    ex && r_r.sub == CH_X
    |=> r_r.pcfg == r_r.s_pcfg && tx_data == CH_RLD && r_r.txn == 3'd5)
    else $error("reload did not apply stored image");
  baud_range_a: assert property ( // R22
    r_r.baud <= MAX_BAUD[2:0] && r_r.s_baud <= MAX_BAUD[2:0])
    else $error("baud code out of range");

  tag_cmd_c: cover property (ex && tb[7] ##1 tx_valid);
  flag_cmd_c: cover property (ex && r_r.sub == CH_F && f_ok);
  reload_c: cover property (ex && r_r.sub == CH_X ##[1:20] r_r.st == S_IDLE);
  err_c: cover property (tx_acc && tx_data == CH_ERR);

endmodule
`default_nettype wire

/* File: verif/rcc_host.sv */
// Host model on the serial command link of the configuration handler.
// Assumes it is called right after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rcc_host
(
  input  wire logic       ref_clk,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] rep_q[$];

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Each character is held until rx_ready is seen high at an edge
  task automatic send_cmd(input string s);
    int n;
    for (int i = 0; i < s.len(); i++)
    begin
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      n = 0;
      @(posedge ref_clk);
      while (rx_ready !== 1'b1 && n < 50)
      begin
        n++;
        @(posedge ref_clk);
      end
    end
    rx_valid <= 1'b0;
    // Released data must not look like the last character
    rx_data  <= ~s[s.len()-1];
  endtask

  // Slow mode stalls the transmitter every other cycle
  task automatic get_reply(input bit slow);
    int k;
    rep_q.delete();
    tx_ready <= !slow;
    for (k = 0; k < 60; k++)
    begin
      @(posedge ref_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
        rep_q.push_back(tx_data);
      else if (rep_q.size() > 0 && tx_valid !== 1'b1)
        break;
      if (slow && k < 59)
        tx_ready <= ~tx_ready;
    end
    tx_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/reader_config_command_handler_test.sv */
// Self-checking bench for the configuration command handler.
// Assumes the host model drives the command link; ce is held high except in t_freeze.
`timescale 1ns/1ps
`default_nettype none
module reader_config_command_handler_test;
  import rcc_pkg::*;
  logic        ref_clk, rst, ce, rx_valid, rx_ready, tx_valid, tx_ready;
  logic        bus_wr, bus_rd, proto_code;
  logic        skip_rx_frame_start, skip_rx_extra_guard, skip_rx_frame_end;
  logic [7:0]  rx_data, tx_data, bus_addr, bus_wdata, bus_rdata, poll_mask;
  logic [7:0]  pcfg_1, pcfg_2, pcfg_3, pcfg_4, mod_cond;
  logic [15:0] poll_timer;
  logic [2:0]  baud_code;
  int          bad_count, cmp_count;

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  rcc_cmd_handler u_rcc_cmd_handler
  (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .poll_mask(poll_mask), .pcfg_1(pcfg_1),
    .pcfg_2(pcfg_2), .pcfg_3(pcfg_3), .pcfg_4(pcfg_4),
    .mod_cond(mod_cond), .poll_timer(poll_timer),
    .skip_rx_frame_start(skip_rx_frame_start),
    .skip_rx_extra_guard(skip_rx_extra_guard),
    .skip_rx_frame_end(skip_rx_frame_end), .proto_code(proto_code),
    .baud_code(baud_code)
  );

  rcc_host u_rcc_host
  (
    .ref_clk(ref_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  task automatic summarize;
    $display("Comparisons: %0d, mismatches: %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Whole command, then the reply compared character by character
  task automatic cmd(input string c, input string e, input bit slow);
    u_rcc_host.send_cmd(c);
    u_rcc_host.get_reply(slow);
    chk8(8'(u_rcc_host.rep_q.size()), 8'(e.len()));
    for (int i = 0; i < e.len(); i++)
      chk8(u_rcc_host.rep_q[i], e[i]);
  endtask

  // One idle cycle after each write keeps strobes single assignments
  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic brd(input logic [7:0] a, input logic [7:0] e);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    // Read data stand only in the cycle after the strobe
    @(negedge ref_clk);
    chk8(bus_rdata, e);
    @(posedge ref_clk);
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic t_tags;
    string      lt;
    logic [7:0] m;
    lt = "abdeisvt";
    for (int i = 0; i < 8; i++)
    begin
      m = (i == 7) ? 8'hFF : ((8'h01 << i) | ((i == 0) ? 8'h80 : 8'h00));
      cmd($sformatf("o%c", lt[i]), $sformatf("O%c", lt[i] - 8'h20), i == 2);
      chk8(poll_mask, m);
    end
    cmd("oa", "OA", 1'b0);
    do_reset();
    chk8(poll_mask, 8'hFF);
  endtask

  task automatic t_flags;
    cmd("of0101", "01", 1'b0);
    chk8(pcfg_1, 8'h02);
    cmd("of0803", "03", 1'b1);
    chk8(pcfg_2, 8'h0C);
    cmd("of0E01", "01", 1'b0);
    chk8({5'h00, skip_rx_frame_end, skip_rx_extra_guard,
          skip_rx_frame_start}, 8'h01);
    cmd("of1501", "01", 1'b0);
    chk8(pcfg_4, 8'h04);
    cmd("of 13 01", "01", 1'b0);
    chk8(pcfg_3, 8'h44);
    cmd("of0C01", "R", 1'b0);
    cmd("of0102", "R", 1'b0);
    chk8(pcfg_1, 8'h02);
    brd(8'h10, 8'h00);
    do_reset();
    chk8(pcfg_1, 8'h00);
    chk8(pcfg_2, 8'h00);
  endtask

  task automatic t_regs;
    cmd("og0450", "50", 1'b0);
    brd(8'h90, 8'h50);
    brd(8'h50, 8'h00);
    cmd("og0112", "12", 1'b0);
    cmd("og0234", "34", 1'b1);
    chk8(poll_timer[15:8], 8'h34);
    chk8(poll_timer[7:0], 8'h12);
    cmd("og0B00", "R", 1'b0);
    cmd("og1000", "R", 1'b0);
    brd(8'h90, 8'h50);
  endtask

  task automatic t_mod;
    bwr(8'h20, 8'hA0);
    bwr(8'h24, 8'h11);
    bwr(8'h28, 8'h22);
    bwr(8'h2C, 8'h33);
    cmd("ox", "X0000", 1'b0);
    chk8(mod_cond, 8'hA0);
    cmd("om02", "0222", 1'b1);
    chk8(mod_cond, 8'h22);
    cmd("om04", "R", 1'b0);
    chk8(mod_cond, 8'h22);
    cmd("og09AB", "AB", 1'b0);
    chk8(mod_cond, 8'hAB);
    brd(8'hD0, 8'h02);
  endtask

  task automatic t_reload;
    brd(8'h00, 8'h7F);
    bwr(8'h04, 8'h01);
    bwr(8'h08, 8'h06);
    bwr(8'h08, 8'h07);
    brd(8'h08, 8'h06);
    brd(8'hE0, 8'h00);
    chk8({4'h0, proto_code, baud_code}, 8'h00);
    cmd("ox", "X0106", 1'b0);
    chk8({4'h0, proto_code, baud_code}, 8'h0E);
    chk8(mod_cond, 8'h22);
    brd(8'hD0, 8'h3A);
  endtask

  // Frozen state ignores the bus and closes both handshakes
  task automatic t_freeze;
    ce <= 1'b0;
    bwr(8'h04, 8'h00);
    chk8({6'h00, rx_ready, tx_valid}, 8'h00);
    ce <= 1'b1;
    brd(8'h04, 8'h01);
  endtask

  initial
  begin
    rst       = 1'b1;
    ce        = 1'b1;
    bus_addr  = 8'h00;
    bus_wdata = 8'h00;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_tags();
    t_flags();
    t_regs();
    t_mod();
    t_reload();
    t_freeze();
    summarize();
  end

  // The tests need a few hundred cycles; this allows about twenty thousand
  initial
  begin
    #1000000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
